// ---- src/manual_fire_key_buf_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef MANUAL_FIRE_KEY_BUF_CONSTS_SVH
`define MANUAL_FIRE_KEY_BUF_CONSTS_SVH

`define OFS_CTRL      12'h000
`define OFS_COUNT     12'h004
`define OFS_CMD       12'h008
`define OFS_STATUS    12'h00C
`define OFS_RIDX      12'h010
`define OFS_RDATA     12'h014
`define OFS_RMETA     12'h018
`define OFS_MAX       12'h01C
`define OFS_MIN       12'h020
`define OFS_MEAN      12'h024
`define OFS_SPREAD    12'h028

`define CTRL_EXT      0
`define CTRL_OUT_LO   1
`define CTRL_IN_LO    3
`define CTRL_REVIEW   5
`define CTRL_RSEL_LO  6
`define CMD_START     0
`define CMD_BUS_MANUAL_FIRE_KEY  1
`define ST_STORING    0
`define ST_OVF        1
`define ST_STATS_OK   2
`define ST_BUSY       3
`define ST_PTR_LO     16
`define META_CHAN_LO  8
`define META_OVF      16

`define COUNT_RESET   11'h002
`define COUNT_MIN     11'h002
`define COUNT_MAX     11'h400

`define CLK_MHZ        50
`define DONE_PULSE_NS  10000
`define DONE_PULSE_CYC ((`DONE_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- src/manual_fire_key_buf_pkg.sv ----
// types shared by the trigger sequencer and reading buffer
package manual_fire_key_buf_pkg;

  typedef enum logic [1:0] {
    S_WAIT  = 2'b00,
    S_MEAS  = 2'b01,
    S_PULSE = 2'b11
  } seq_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_MEAN = 3'b001,
    C_MUL  = 3'b011,
    C_VAR  = 3'b010,
    C_SQRT = 3'b110
  } calc_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] value;
    logic [3:0]  units;
    logic [7:0]  chan;
    logic        ovf;
  } reading_s;

  typedef struct packed {
    logic [31:0] value;
    logic [3:0]  units;
    logic [7:0]  chan;
    logic        ovf;
  } entry_s;

  typedef struct packed {
    logic               ext_mode;
    logic [1:0]         out_sel;
    logic [1:0]         in_sel;
    logic               review_on;
    logic [2:0]         review_sel;
    logic [10:0]        req_cnt;
    logic               storing;
    logic [10:0]        wr_ptr;
    logic               ovf_seen;
    logic               stats_ok;
    logic               pend;
    seq_e               seq;
    logic [15:0]        pulse_cnt;
    logic               sy1;
    logic               sy2;
    logic               sy3;
    logic               kext;
    logic               kfire;
    logic               meas_start;
    logic [5:0]         manual_fire_key_out;
    logic [5:0]         manual_fire_key_oe_n;
    logic [31:0]        max_v;
    logic [31:0]        min_v;
    logic signed [47:0] sum;
    logic [79:0]        sumsq;
    calc_e              calc;
    logic [79:0]        acc;
    logic [41:0]        rem;
    logic [39:0]        root;
    logic [6:0]         cnt;
    logic [31:0]        mean_mag;
    logic [31:0]        mean_fl;
    logic [31:0]        sd_fl;
    logic [9:0]         rd_idx;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               manual_fire_key_led;
    logic               dash_on;
    logic               store_led;
    logic               buf_led;
    logic               stat_led;
  } state_s;

endpackage

// ---- src/trigger_lines_reading_buffer.sv ----
// trigger-line sequencer, reading buffer and statistics with apb registers
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "manual_fire_key_buf_consts.svh"

module trigger_lines_reading_buffer #(
  parameter int DEPTH = 1024
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [5:0]            manual_fire_key_in,
  output logic      [5:0]            manual_fire_key_out,
  output logic      [5:0]            manual_fire_key_oe_n,
  input  wire logic                  ext_key,
  input  wire logic                  fire_key,
  output logic                       meas_start,
  input  wire manual_fire_key_buf_pkg::reading_s meas_rd,
  output logic                       manual_fire_key_led,
  output logic                       dash_on,
  output logic                       store_led,
  output logic                       buf_led,
  output logic                       stat_led
);

  manual_fire_key_buf_pkg::state_s q;
  manual_fire_key_buf_pkg::state_s d;
  manual_fire_key_buf_pkg::entry_s mem [DEPTH];
  manual_fire_key_buf_pkg::entry_s rd_ent;
  logic                 mem_we;
  logic                 fall;
  logic                 fire_ev;
  logic                 bus_manual_fire_key;
  logic                 start;
  logic                 hit;
  logic [31:0]          rmux;
  logic signed [31:0]   fx;
  logic [79:0]          sq;
  logic [47:0]          sum_mag;
  logic [11:0]          dvs;
  logic [11:0]          dr;
  logic [41:0]          sr;
  logic [41:0]          trial;
  logic [79:0]          prod;
  logic [10:0]          ptr_n;
  logic [10:0]          cnt_w;

  function automatic logic fl_lt(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31]) begin
      return a[31];
    end
    return a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
  endfunction

  // ieee single to signed fixed with 16 fraction bits, saturating
  function automatic logic signed [31:0] fl2fx(input logic [31:0] f);
    logic [7:0]  e;
    logic [54:0] m;
    logic [31:0] mag;
    e = f[30:23];
    m = {31'h0000_0000, 1'b1, f[22:0]};
    if (e < 8'h68) begin
      mag = 32'h0000_0000;
    end else if (e > 8'h8D) begin
      mag = 32'h7FFF_FFFF;
    end else if (e >= 8'h86) begin
      mag = 32'(m << (e - 8'h86));
    end else begin
      mag = 32'(m >> (8'h86 - e));
    end
    return f[31] ? -mag : mag;
  endfunction

  // signed fixed with 16 fraction bits to ieee single, truncating
  function automatic logic [31:0] fx2fl(input logic signed [47:0] v);
    logic [47:0] m;
    logic [47:0] n;
    logic [5:0]  p;
    m = v[47] ? 48'(-v) : v;
    p = 6'h00;
    for (int i = 0; i < 48; i++) begin
      if (m[i]) begin
        p = 6'(i);
      end
    end
    if (m == 48'h0000_0000_0000) begin
      return 32'h0000_0000;
    end
    n = (p > 6'h17) ? (m >> (p - 6'h17)) : (m << (6'h17 - p));
    return {v[47], 8'({2'b00, p} + 8'h6F), n[22:0]};
  endfunction

  assign rd_ent  = mem[q.rd_idx];
  assign fx      = fl2fx(meas_rd.value);
  assign sq      = {16'h0000, 64'(fx * fx)};
  assign sum_mag = q.sum[47] ? 48'(-q.sum) : 48'(q.sum);
  assign ptr_n   = q.wr_ptr + 11'h001;
  assign dvs     = (q.calc == manual_fire_key_buf_pkg::C_MEAN) ? {1'b0, q.wr_ptr}
                                                    : {1'b0, q.wr_ptr - 11'h001};
  assign dr      = {q.rem[10:0], q.acc[79]};
  assign sr      = {q.rem[39:0], q.acc[79:78]};
  assign trial   = {q.root, 2'b01};
  assign prod    = 80'({32'h0000_0000, sum_mag} * {48'h0000_0000_0000, q.mean_mag});

  // register read mux; statistics read zero unless valid
  always_comb begin
    hit  = 1'b1;
    rmux = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: begin
        rmux[`CTRL_EXT]                   = q.ext_mode;
        rmux[`CTRL_OUT_LO+1:`CTRL_OUT_LO] = q.out_sel;
        rmux[`CTRL_IN_LO+1:`CTRL_IN_LO]   = q.in_sel;
        rmux[`CTRL_REVIEW]                = q.review_on;
        rmux[`CTRL_RSEL_LO+2:`CTRL_RSEL_LO] = q.review_sel;
      end
      `OFS_COUNT: rmux[10:0] = q.req_cnt;
      `OFS_CMD: rmux = 32'h0000_0000;
      `OFS_STATUS: begin
        rmux[`ST_STORING] = q.storing;
        rmux[`ST_OVF]     = q.ovf_seen;
        rmux[`ST_STATS_OK] = q.stats_ok;
        rmux[`ST_BUSY]    = (q.calc != manual_fire_key_buf_pkg::C_IDLE);
        rmux[`ST_PTR_LO+10:`ST_PTR_LO] = q.wr_ptr;
      end
      `OFS_RIDX: rmux[9:0] = q.rd_idx;
      `OFS_RDATA: rmux = rd_ent.value;
      `OFS_RMETA: begin
        rmux[3:0] = rd_ent.units;
        rmux[`META_CHAN_LO+7:`META_CHAN_LO] = rd_ent.chan;
        rmux[`META_OVF] = rd_ent.ovf;
      end
      `OFS_MAX:    rmux = q.stats_ok ? q.max_v : 32'h0000_0000;
      `OFS_MIN:    rmux = q.stats_ok ? q.min_v : 32'h0000_0000;
      `OFS_MEAN:   rmux = q.stats_ok ? q.mean_fl : 32'h0000_0000;
      `OFS_SPREAD: rmux = q.stats_ok ? q.sd_fl : 32'h0000_0000;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    d          = q;
    mem_we     = 1'b0;
    bus_manual_fire_key   = 1'b0;
    start      = 1'b0;
    cnt_w      = 11'h000;
    d.pready   = 1'b0;
    d.pslverr  = 1'b0;
    d.meas_start = 1'b0;
    d.manual_fire_key_out = 6'h00;

    // apb: answer one cycle into access, write at the completing edge
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.prdata  = rmux;
      d.pslverr = !hit;
    end
    if (psel && penable && q.pready && pwrite) begin
      case (paddr)
        `OFS_CTRL: begin
          d.ext_mode  = pwdata[`CTRL_EXT];
          d.out_sel   = (pwdata[`CTRL_OUT_LO+1:`CTRL_OUT_LO] == 2'h3) ? 2'h0
                        : pwdata[`CTRL_OUT_LO+1:`CTRL_OUT_LO];
          d.in_sel    = (pwdata[`CTRL_IN_LO+1:`CTRL_IN_LO] == 2'h3) ? 2'h0
                        : pwdata[`CTRL_IN_LO+1:`CTRL_IN_LO];
          d.review_on = pwdata[`CTRL_REVIEW];
          d.review_sel = pwdata[`CTRL_RSEL_LO+2:`CTRL_RSEL_LO];
        end
        `OFS_COUNT: begin
          cnt_w = pwdata[10:0];
          if (pwdata[31:11] != 21'h00_0000 || cnt_w > `COUNT_MAX) begin
            cnt_w = `COUNT_MAX;
          end else if (cnt_w < `COUNT_MIN) begin
            cnt_w = `COUNT_MIN;
          end
          d.req_cnt = cnt_w;
        end
        `OFS_CMD: begin
          start    = pwdata[`CMD_START];
          bus_manual_fire_key = pwdata[`CMD_BUS_MANUAL_FIRE_KEY];
        end
        `OFS_RIDX: d.rd_idx = pwdata[9:0];
        default: d.rd_idx = q.rd_idx;
      endcase
    end

    // start line: selected pin, two-stage synchroniser, falling edge
    d.sy1 = manual_fire_key_in[{q.in_sel, 1'b1}];
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    fall  = q.sy3 && !q.sy2;

    d.kext  = ext_key;
    d.kfire = fire_key;
    if (ext_key && !q.kext) begin
      d.ext_mode = !q.ext_mode;
    end
    fire_ev = fire_key && !q.kfire;

    case (q.seq)
      manual_fire_key_buf_pkg::S_WAIT: begin
        if (!q.ext_mode || q.pend) begin
          d.pend       = 1'b0;
          d.meas_start = 1'b1;
          d.seq        = manual_fire_key_buf_pkg::S_MEAS;
        end
      end
      manual_fire_key_buf_pkg::S_MEAS: begin
        if (meas_rd.valid) begin
          d.seq       = manual_fire_key_buf_pkg::S_PULSE;
          d.pulse_cnt = 16'h0000;
          d.manual_fire_key_oe_n = 6'h3F;
          d.manual_fire_key_oe_n[{q.out_sel, 1'b0}] = 1'b0;
          if (q.storing) begin
            mem_we     = 1'b1;
            d.wr_ptr   = ptr_n;
            d.ovf_seen = q.ovf_seen || meas_rd.ovf;
            d.sum      = q.sum + 48'(fx);
            d.sumsq    = q.sumsq + sq;
            if (q.wr_ptr == 11'h000 || fl_lt(q.max_v, meas_rd.value)) begin
              d.max_v = meas_rd.value;
            end
            if (q.wr_ptr == 11'h000 || fl_lt(meas_rd.value, q.min_v)) begin
              d.min_v = meas_rd.value;
            end
            if (ptr_n == q.req_cnt) begin
              d.storing = 1'b0;
              d.calc    = manual_fire_key_buf_pkg::C_MEAN;
              d.acc     = {32'h0000_0000, d.sum[47] ? 48'(-d.sum) : 48'(d.sum)};
              d.rem     = 42'h000_0000_0000;
              d.cnt     = 7'h00;
            end
          end
        end
      end
      manual_fire_key_buf_pkg::S_PULSE: begin
        d.pulse_cnt = q.pulse_cnt + 16'h0001;
        if (q.pulse_cnt == 16'(`DONE_PULSE_CYC - 1)) begin
          d.manual_fire_key_oe_n = 6'h3F;
          d.seq       = manual_fire_key_buf_pkg::S_WAIT;
        end
      end
      default: d.seq = manual_fire_key_buf_pkg::S_WAIT;
    endcase

    // pending event set after its consumption, so a new edge is kept
    if (q.ext_mode && (fall || fire_ev || bus_manual_fire_key)) begin
      d.pend = 1'b1;
    end

    // statistics engine: restoring divide, product, divide, square root
    case (q.calc)
      manual_fire_key_buf_pkg::C_MEAN, manual_fire_key_buf_pkg::C_VAR: begin
        d.cnt = q.cnt + 7'h01;
        if (dr >= dvs) begin
          d.rem = {30'h0000_0000, dr - dvs};
          d.acc = {q.acc[78:0], 1'b1};
        end else begin
          d.rem = {30'h0000_0000, dr};
          d.acc = {q.acc[78:0], 1'b0};
        end
        if (q.cnt == 7'h4F) begin
          d.cnt = 7'h00;
          d.rem = 42'h000_0000_0000;
          if (q.calc == manual_fire_key_buf_pkg::C_MEAN) begin
            d.mean_mag = d.acc[31:0];
            d.calc     = manual_fire_key_buf_pkg::C_MUL;
          end else begin
            d.root = 40'h00_0000_0000;
            d.calc = manual_fire_key_buf_pkg::C_SQRT;
          end
        end
      end
      manual_fire_key_buf_pkg::C_MUL: begin
        d.mean_fl = fx2fl(q.sum[47] ? -48'(q.mean_mag) : 48'(q.mean_mag));
        d.acc     = (q.sumsq >= prod) ? q.sumsq - prod : 80'h0;
        d.calc    = manual_fire_key_buf_pkg::C_VAR;
      end
      manual_fire_key_buf_pkg::C_SQRT: begin
        d.cnt = q.cnt + 7'h01;
        d.acc = {q.acc[77:0], 2'b00};
        if (sr >= trial) begin
          d.rem  = sr - trial;
          d.root = {q.root[38:0], 1'b1};
        end else begin
          d.rem  = sr;
          d.root = {q.root[38:0], 1'b0};
        end
        if (q.cnt == 7'h27) begin
          d.sd_fl    = fx2fl({8'h00, d.root});
          d.stats_ok = !q.ovf_seen;
          d.calc     = manual_fire_key_buf_pkg::C_IDLE;
        end
      end
      default: d.calc = (q.calc == manual_fire_key_buf_pkg::C_IDLE) ? d.calc : manual_fire_key_buf_pkg::C_IDLE;
    endcase

    if (start) begin
      d.storing  = 1'b1;
      d.wr_ptr   = 11'h000;
      d.ovf_seen = 1'b0;
      d.stats_ok = 1'b0;
      d.sum      = 48'h0000_0000_0000;
      d.sumsq    = 80'h0;
      d.calc     = manual_fire_key_buf_pkg::C_IDLE;
    end

    d.manual_fire_key_led  = d.ext_mode;
    d.dash_on   = d.ext_mode && (d.seq == manual_fire_key_buf_pkg::S_WAIT);
    d.store_led = d.storing;
    d.buf_led   = d.review_on;
    d.stat_led  = d.review_on && (d.review_sel != 3'h0) && d.stats_ok;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q           <= '0;
      q.req_cnt   <= `COUNT_RESET;
      q.seq       <= manual_fire_key_buf_pkg::S_WAIT;
      q.calc      <= manual_fire_key_buf_pkg::C_IDLE;
      q.manual_fire_key_oe_n <= 6'h3F;
      q.sy1       <= 1'b1;
      q.sy2       <= 1'b1;
      q.sy3       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // buffer array; overwritten from index zero by each new storage run
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[q.wr_ptr[9:0]] <= {meas_rd.value, meas_rd.units, meas_rd.chan, meas_rd.ovf};
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign manual_fire_key_out   = q.manual_fire_key_out;
  assign manual_fire_key_oe_n  = q.manual_fire_key_oe_n;
  assign meas_start = q.meas_start;
  assign manual_fire_key_led   = q.manual_fire_key_led;
  assign dash_on    = q.dash_on;
  assign store_led  = q.store_led;
  assign buf_led    = q.buf_led;
  assign stat_led   = q.stat_led;

endmodule

// ---- testbench/manual_fire_key_buf_monitor.sv ----
// assertion checker on the ports of the trigger sequencer
`timescale 1ns/1ns
`include "manual_fire_key_buf_consts.svh"

module manual_fire_key_buf_monitor (
  input wire logic                   core_clk,
  input wire logic                   srst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [5:0]             manual_fire_key_out,
  input wire logic [5:0]             manual_fire_key_oe_n,
  input wire logic                   meas_start,
  input wire manual_fire_key_buf_pkg::reading_s meas_rd,
  input wire logic                   manual_fire_key_led,
  input wire logic                   dash_on,
  input wire logic                   buf_led,
  input wire logic                   stat_led
);
  localparam int DONE_CYC = `DONE_PULSE_CYC;
  logic [15:0] low_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // cycles the done line has been low so far
  always_ff @(posedge core_clk) begin
    if (srst || manual_fire_key_oe_n == 6'h3f) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end

  sequence s_wait_then_ready;
    !pready ##1 pready;
  endsequence

  sequence s_one_line_low;
    $countones(~manual_fire_key_oe_n) == 1;
  endsequence

  a_apb_one_wait: assert property (psel && !penable |=> s_wait_then_ready)
    else $error("apb answer not after one wait");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("slverr without ready");
  a_done_width: assert property ($rose(manual_fire_key_oe_n == 6'h3f) |-> low_q == 16'(DONE_CYC))
    else $error("done pulse width wrong");
  a_done_after_meas: assert property (meas_rd.valid |=> s_one_line_low)
    else $error("no done pulse after reading");
  a_done_cause: assert property ($fell(manual_fire_key_oe_n == 6'h3f) |-> $past(meas_rd.valid))
    else $error("done pulse without reading");
  a_done_lines: assert property ((manual_fire_key_oe_n & 6'h2a) == 6'h2a)
    else $error("done driven on an input line");
  a_out_level: assert property (manual_fire_key_out == 6'h00)
    else $error("trigger output level not low");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  a_start_idle: assert property (manual_fire_key_oe_n != 6'h3f |-> !meas_start)
    else $error("start during done pulse");
  a_dash_ext: assert property (dash_on |-> manual_fire_key_led)
    else $error("dashes outside external mode");
  a_stat_buf: assert property (stat_led |-> buf_led)
    else $error("stat lit outside review");
endmodule

bind trigger_lines_reading_buffer manual_fire_key_buf_monitor mon_u (
  .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .manual_fire_key_out(manual_fire_key_out), .manual_fire_key_oe_n(manual_fire_key_oe_n), .meas_start(meas_start),
  .meas_rd(meas_rd), .manual_fire_key_led(manual_fire_key_led), .dash_on(dash_on), .buf_led(buf_led),
  .stat_led(stat_led)
);

// ---- testbench/scan_partner.sv ----
// behavioural relay scanner on the trigger lines
`timescale 1ns/1ns

module scan_partner (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [3:0] nchan,
  input  wire logic [2:0] in_line,
  input  wire logic [2:0] out_line,
  input  wire logic [5:0] lines,
  output logic      [5:0] drive_n,
  output logic      [3:0] closed
);
  initial begin
    drive_n = 6'h3f;
    closed = 4'h0;
    forever begin
      @(posedge core_clk);
      if (go && closed < nchan) begin
        if (closed != 4'h0) begin
          while (lines[out_line] !== 1'b0) @(posedge core_clk);
          while (lines[out_line] !== 1'b1) @(posedge core_clk);
        end
        // relay settling, then channel ready as a falling edge
        repeat (20) @(posedge core_clk);
        drive_n[in_line] <= 1'b0;
        repeat (8) @(posedge core_clk);
        drive_n <= 6'h3f;
        closed <= closed + 4'h1;
      end else if (!go) begin
        closed <= 4'h0;
      end
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// bench: apb traffic, keys, scanner handshake and buffer statistics
`timescale 1ns/1ns
`include "manual_fire_key_buf_consts.svh"

module tb_top;
  logic                   core_clk, srst, psel, penable, pwrite, ext_key, fire_key, go;
  logic                   pready, pslverr, e, meas_start;
  logic                   manual_fire_key_led, dash_on, store_led, buf_led, stat_led;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, q, seed;
  logic [5:0]             manual_fire_key_in, manual_fire_key_out, manual_fire_key_oe_n, drive_n;
  logic [2:0]             in_line, out_line;
  logic [3:0]             nchan, closed;
  manual_fire_key_buf_pkg::reading_s meas_rd;
  logic [31:0]            log_v [64];
  logic [31:0]            log_m [64];
  int                     errors, comparisons, starts, cycles, nlog, base, ovf_at, mdly, sb, n;
  int                     sel_t [3] = '{0, 1, 2};
  int                     cnt_t [3] = '{2, 5, 4};
  int                     ovf_t [3] = '{-1, -1, 2};
  real                    mx, mn, mu, sd;

  // open-drain lines with pull-ups
  assign manual_fire_key_in = (manual_fire_key_out | manual_fire_key_oe_n) & drive_n;

  trigger_lines_reading_buffer dut_u (
    .core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .manual_fire_key_in(manual_fire_key_in), .manual_fire_key_out(manual_fire_key_out), .manual_fire_key_oe_n(manual_fire_key_oe_n), .ext_key(ext_key),
    .fire_key(fire_key), .meas_start(meas_start), .meas_rd(meas_rd), .manual_fire_key_led(manual_fire_key_led),
    .dash_on(dash_on), .store_led(store_led), .buf_led(buf_led), .stat_led(stat_led));

  scan_partner scan_u (.core_clk(core_clk), .go(go), .nchan(nchan), .in_line(in_line),
    .out_line(out_line), .lines(manual_fire_key_in), .drive_n(drive_n), .closed(closed));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic void expect_stats(input int b, input int k, output real hi,
                                       output real lo, output real m, output real d);
    real x, s, s2;
    hi = -1.0e9;
    lo = 1.0e9;
    s = 0.0;
    s2 = 0.0;
    for (int i = 0; i < k; i++) begin
      x = $bitstoshortreal(log_v[(b + i) % 64]);
      hi = x > hi ? x : hi;
      lo = x < lo ? x : lo;
      s = s + x;
      s2 = s2 + x * x;
    end
    m = s / k;
    d = $sqrt((s2 - s * s / k) / (k - 1));
  endfunction

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] s);
    comparisons++;
    if (s !== ex) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, s);
    end
  endtask

  task automatic near(input string nm, input real ex, input logic [31:0] s);
    real x, tol;
    x = $bitstoshortreal(s);
    tol = 0.001 + 0.001 * (ex < 0 ? -ex : ex);
    comparisons++;
    if (x > ex + tol || x < ex - tol) begin
      errors++;
      $display("wrong value %s expected %f seen %f", nm, ex, x);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic press(input logic fire);
    @(posedge core_clk);
    if (fire) fire_key <= 1'b1;
    else ext_key <= 1'b1;
    repeat (4) @(posedge core_clk);
    fire_key <= 1'b0;
    ext_key <= 1'b0;
  endtask

  task automatic wait_idle(input int target);
    n = 0;
    while ((starts < target || manual_fire_key_oe_n !== 6'h3f) && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20000) errors++;
    @(negedge core_clk);
  endtask

  // measurement engine answering each start after a random delay
  always @(posedge core_clk) begin
    if (!srst && mdly == 1) begin
      seed = xs(seed);
      log_v[nlog % 64] = $shortrealtobits(shortreal'(int'(seed % 100) - 50));
      log_m[nlog % 64] = {15'h0000, nlog - base == ovf_at, 4'h0, closed, 4'h0, seed[11:8]};
      meas_rd <= '{1'b1, log_v[nlog % 64], seed[11:8], {4'h0, closed}, nlog - base == ovf_at};
      nlog = nlog + 1;
    end else begin
      meas_rd.valid <= 1'b0;
    end
    if (srst) mdly <= 0;
    else if (meas_start === 1'b1) begin
      starts <= starts + 1;
      mdly <= 3 + int'(seed[2:0]);
    end else if (mdly > 0) mdly <= mdly - 1;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    {srst, psel, penable, pwrite, ext_key, fire_key, go} = 7'h40;
    {paddr, pwdata, in_line, out_line, nchan} = '0;
    meas_rd = '0;
    seed = 32'h2fe1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check("reset oe_n", 32'h0000_003f, 32'(manual_fire_key_oe_n));
    check("reset leds", 32'h0, 32'({manual_fire_key_led, dash_on, store_led, buf_led, stat_led}));
    apb(1'b0, `OFS_COUNT, 32'h0);
    check("count reset", 32'(`COUNT_RESET), q);
    apb(1'b1, `OFS_COUNT, 32'h0000_0001);
    apb(1'b0, `OFS_COUNT, 32'h0);
    check("count low clamp", 32'(`COUNT_MIN), q);
    apb(1'b1, `OFS_COUNT, 32'h0000_0800);
    apb(1'b0, `OFS_COUNT, 32'h0);
    check("count high clamp", 32'(`COUNT_MAX), q);
    apb(1'b0, 12'h0fc, 32'h0);
    check("unmapped data", 32'h0, q);
    check("unmapped err", 32'h1, 32'(e));
    wait_idle(2);
    check("continuous runs", 32'h1, 32'(starts >= 2));
    in_line <= 3'h1;
    nchan <= 4'h1;
    go <= 1'b1;
    repeat (40) @(posedge core_clk);
    go <= 1'b0;
    press(1'b0);
    repeat (20) @(posedge core_clk);
    wait_idle(starts);
    check("ext leds", 32'h3, 32'({manual_fire_key_led, dash_on}));
    sb = starts;
    repeat (300) @(posedge core_clk);
    check("no event", 32'(sb), 32'(starts));
    press(1'b1);
    wait_idle(sb + 1);
    check("fire once", 32'(sb + 1), 32'(starts));
    apb(1'b1, `OFS_CMD, 32'h0000_0002);
    wait_idle(sb + 2);
    check("bus trigger", 32'(sb + 2), 32'(starts));
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, `OFS_CTRL, 32'(1 | sel_t[r] << 1 | sel_t[r] << 3));
      apb(1'b1, `OFS_COUNT, 32'(cnt_t[r]));
      ovf_at = ovf_t[r];
      base = nlog;
      sb = starts;
      apb(1'b1, `OFS_CMD, 32'h0000_0001);
      repeat (2) @(negedge core_clk);
      check("store led on", 32'h1, 32'(store_led));
      in_line <= 3'(2 * sel_t[r] + 1);
      out_line <= 3'(2 * sel_t[r]);
      nchan <= 4'(cnt_t[r] + 1);
      go <= 1'b1;
      wait_idle(sb + cnt_t[r] + 1);
      go <= 1'b0;
      check("starts", 32'(sb + cnt_t[r] + 1), 32'(starts));
      apb(1'b0, `OFS_STATUS, 32'h0);
      check("stored count", 32'(cnt_t[r]), 32'(q[26:16]));
      check("stats ok", 32'(ovf_at < 0), 32'(q[`ST_STATS_OK]));
      check("store led off", 32'h0, 32'(store_led));
      for (int i = 0; i < cnt_t[r]; i++) begin
        apb(1'b1, `OFS_RIDX, 32'(i));
        apb(1'b0, `OFS_RDATA, 32'h0);
        check("entry value", log_v[(base + i) % 64], q);
        apb(1'b0, `OFS_RMETA, 32'h0);
        check("entry meta", log_m[(base + i) % 64], q);
      end
      expect_stats(base, cnt_t[r], mx, mn, mu, sd);
      apb(1'b0, `OFS_MAX, 32'h0);
      check("max", ovf_at < 0 ? $shortrealtobits(shortreal'(mx)) : 32'h0, q);
      apb(1'b0, `OFS_MIN, 32'h0);
      check("min", ovf_at < 0 ? $shortrealtobits(shortreal'(mn)) : 32'h0, q);
      apb(1'b0, `OFS_MEAN, 32'h0);
      if (ovf_at < 0) near("mean", mu, q);
      else check("mean off", 32'h0, q);
      apb(1'b0, `OFS_SPREAD, 32'h0);
      if (ovf_at < 0) near("spread", sd, q);
      else check("spread off", 32'h0, q);
      apb(1'b1, `OFS_CTRL, 32'(1 | sel_t[r] << 1 | sel_t[r] << 3 | 3 << 5));
      @(negedge core_clk);
      check("review leds", 32'(ovf_at < 0 ? 3 : 2), 32'({buf_led, stat_led}));
    end
    press(1'b0);
    repeat (10) @(negedge core_clk);
    check("continuous again", 32'h0, 32'(manual_fire_key_led));
    conclude();
  end
endmodule
